// File: design/qcd_pkg.sv
// Package with register map, field layouts and sizing constants for the queue admission block.
package qcd_pkg;
    localparam int NUM_PRIO       = 8;
    localparam int NUM_PROFILES   = 16;
    localparam int PROF_IDX_W     = 4;
    localparam int PROFILE_ID_MAX = 384;
    localparam int PCT_FULL       = 100;
    localparam int DEPTH_W        = 20;
    localparam int DATA_W         = 64;
    localparam int ADDR_W         = 8;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] REG_PORT_SIZE  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_PORT_THR   = 8'h08;
    localparam logic [ADDR_W-1:0] REG_DEFAULT_UP = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h10;
    localparam logic [ADDR_W-1:0] REG_DROP_CNT   = 8'h14;
    localparam logic [ADDR_W-1:0] REG_ACCEPT_CNT = 8'h18;
    localparam logic [ADDR_W-1:0] REG_TOTAL_OCC  = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_COS_THR0   = 8'h20;
    localparam logic [ADDR_W-1:0] REG_COS_PROF0  = 8'h40;
    localparam logic [ADDR_W-1:0] REG_PROF0      = 8'h80;

    // Control register fields.
    localparam int CTRL_TRUST_BIT   = 0;
    localparam int CTRL_REWRITE_BIT = 1;
    localparam int CTRL_VID_OVR_BIT = 2;
    localparam int CTRL_RED_EN_BIT  = 3;
    localparam int CTRL_VID_LSB     = 16;
    localparam int VID_W            = 12;

    // Profile register fields: min[6:0], max[14:8], prob[22:16], id[31:23].
    localparam int PROF_MIN_LSB  = 0;
    localparam int PROF_MAX_LSB  = 8;
    localparam int PROF_PROB_LSB = 16;
    localparam int PROF_ID_LSB   = 23;
    localparam int PCT_W         = 7;
    localparam int PROF_ID_W     = 9;

    // Reset values, error read value and bus response codes.
    localparam logic [31:0] PORT_SIZE_RST = 32'h0001_0000;
    localparam logic [31:0] RESP_ERR_VAL  = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// File: design/queue_congestion_drop.sv
// Ingress queue admission with tail drop, per-priority thresholds and random early discard.
//
// Behaviour
// - Map each frame to a user priority, then to one of eight unicast or multicast queues.
// - Untrusted ports use the default priority map; trusted ports take the received CoS field.
// - With rewriting on, outgoing CoS comes from the derived priority; VLAN ID may be overridden.
// - Without extra configuration frames stay in order and drop only when the buffer is full.
// - Once a multicast queue reaches its priority threshold, further multicast frames of that priority are dropped.
// - Nine tail-drop thresholds per port: one port total and eight per priority.
// - Per-priority thresholds act only on multicast frames, never on unicast.
// - A priority whose multicast queue has used up its allotment drops new multicast frames until occupancy falls below.
// - A threshold sum below the buffer is allocated as set; the rest stays unassigned.
// - Each discard profile has an id 0 to 384 and min, max, probability in percent.
// - Profile min and max percentages become byte thresholds scaled by the port queue size.
// - Between min and max occupancy, frames drop at random with the set probability.
// - Above the profile maximum every arriving frame of that queue is dropped.
// - Each CoS value 0 to 7 can be bound to a chosen discard profile.
// - Only a limited number of discard profiles exist in the whole device.
`timescale 1ns/1ps
`default_nettype none
module queue_congestion_drop
    import qcd_pkg::*;
#(
    parameter int PROFILES = NUM_PROFILES,          // Number of profile slots.
    parameter int DW       = DATA_W                  // Frame word width.
) (
    input  wire logic              clk_in,            // 25 MHz clock.
    input  wire logic              rst_in,            // Synchronous reset, active high.
    input  wire logic [ADDR_W-1:0] avs_address_in,    // Register byte address.
    input  wire logic              avs_read_in,       // Read request.
    input  wire logic              avs_write_in,      // Write request.
    input  wire logic [31:0]       avs_writedata_in,  // Write data.
    input  wire logic [3:0]        avs_byteenable_in, // Byte enables.
    output logic [31:0]            avs_readdata_out,  // Read data.
    output logic                   avs_waitrequest_out, // Stall until answer.
    output logic [1:0]             avs_response_out,  // OKAY or SLVERR.
    input  wire logic              in_valid_in,       // Arriving frame descriptor valid.
    output logic                   in_ready_out,      // Admission can take a frame.
    input  wire logic [DW-1:0]     in_data_in,        // Frame handle or word.
    input  wire logic [15:0]       in_len_in,         // Frame length in bytes.
    input  wire logic [2:0]        in_cos_in,         // Received CoS field.
    input  wire logic [VID_W-1:0]  in_vid_in,         // Received VLAN ID.
    input  wire logic              in_mcast_in,       // Frame is multicast.
    output logic                   out_valid_out,     // Admitted frame valid.
    input  wire logic              out_ready_in,      // Queue writer takes the frame.
    output logic [DW-1:0]          out_data_out,      // Admitted frame word.
    output logic [15:0]            out_len_out,       // Admitted frame length.
    output logic [2:0]             out_cos_out,       // Outgoing CoS field.
    output logic [VID_W-1:0]       out_vid_out,       // Outgoing VLAN ID.
    output logic [3:0]             out_queue_out,     // {mcast, traffic class}.
    input  wire logic              free_valid_in,     // A queued frame left the buffer.
    input  wire logic [3:0]        free_queue_in,     // Queue it left.
    input  wire logic [15:0]       free_len_in,       // Its length in bytes.
    output logic                   drop_out           // One-cycle pulse per dropped frame.
);
    localparam int QN = 2 * NUM_PRIO;
    localparam int BW = DW + 16 + 3 + VID_W + 4;

    // Configuration state written by software.
    logic [31:0]        ctrl_reg;
    logic [DEPTH_W-1:0] port_size_reg;
    logic [DEPTH_W-1:0] port_thr_reg;
    logic [2:0]         default_up_reg;
    logic [PCT_W-1:0]   cos_thr_reg [NUM_PRIO];
    logic [PROF_IDX_W-1:0] cos_prof_reg [NUM_PRIO];
    logic [31:0]        prof_reg [PROFILES];
    logic               cfg_err_reg;
    // Occupancy and statistics.
    logic [DEPTH_W-1:0] qocc_reg [QN];
    logic [DEPTH_W-1:0] total_reg;
    logic [31:0]        drop_cnt_reg;
    logic [31:0]        acc_cnt_reg;
    logic [15:0]        lfsr_reg;
    logic               drop_reg;

    // Percentage of a byte size, rounded down; shared by tail drop and discard profiles.
    function automatic logic [DEPTH_W-1:0] pct_of(input logic [DEPTH_W-1:0] size, input logic [PCT_W-1:0] pct);
        logic [DEPTH_W+PCT_W-1:0] prod;
        prod = size * pct;
        return DEPTH_W'(prod / PCT_FULL);
    endfunction

    // Priority derivation and queue choice.
    wire        trusted  = ctrl_reg[CTRL_TRUST_BIT];
    wire [2:0]  up       = trusted ? in_cos_in : default_up_reg;
    wire [3:0]  qsel     = {in_mcast_in, up};
    wire [DEPTH_W-1:0] qdepth = qocc_reg[qsel];
    wire [DEPTH_W-1:0] nlen   = DEPTH_W'(in_len_in);

    // Tail drop checks; the port limit and the physical buffer always apply.
    wire buf_full  = (total_reg + nlen) > port_size_reg;
    wire port_over = (total_reg + nlen) > port_thr_reg;
    wire [DEPTH_W-1:0] cos_lim = pct_of(port_size_reg, cos_thr_reg[up]);
    wire cos_over  = in_mcast_in && (qdepth >= cos_lim);

    // Random early discard using the profile bound to this priority.
    wire [31:0] prof = prof_reg[cos_prof_reg[up]];
    wire [DEPTH_W-1:0] red_min = pct_of(port_size_reg, prof[PROF_MIN_LSB +: PCT_W]);
    wire [DEPTH_W-1:0] red_max = pct_of(port_size_reg, prof[PROF_MAX_LSB +: PCT_W]);
    wire [15:0] rnd_mul = 16'(lfsr_reg[7:0]) * 16'h0064;
    wire [PCT_W-1:0] rnd_pct = rnd_mul[14:8];
    wire red_on    = ctrl_reg[CTRL_RED_EN_BIT];
    wire red_band  = (qdepth > red_min) && (qdepth <= red_max);
    wire red_drop  = red_on && ((qdepth > red_max) ||
                     (red_band && (rnd_pct < prof[PROF_PROB_LSB +: PCT_W])));
    wire drop_now  = buf_full || port_over || cos_over || red_drop;

    // Two-entry buffer toward the queue writer: the output registers hold the head and a spare
    // entry catches a frame taken while the writer stalls, so a stall loses no admitted frame.
    logic [BW-1:0] spare_reg;
    logic          spare_valid_reg;
    wire           take       = in_valid_in && in_ready_out;
    wire           accept     = take && !drop_now;
    wire           head_free  = !out_valid_out || out_ready_in;
    wire           spare_next = !head_free && (spare_valid_reg || accept);
    wire [2:0]     cos_o     = ctrl_reg[CTRL_REWRITE_BIT] ? up : in_cos_in;
    wire [VID_W-1:0] vid_o   = ctrl_reg[CTRL_VID_OVR_BIT] ? ctrl_reg[CTRL_VID_LSB +: VID_W] : in_vid_in;
    wire [BW-1:0]  entry     = {in_data_in, in_len_in, cos_o, vid_o, qsel};
    wire [BW-1:0]  head      = spare_valid_reg ? spare_reg : entry;

    // Spare entry; ready is registered, so it is withheld while the spare is full.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            spare_valid_reg <= 1'b0;
            in_ready_out    <= 1'b0;
        end else begin
            if (accept && !head_free) begin
                spare_reg <= entry;
            end
            spare_valid_reg <= spare_next;
            in_ready_out    <= !spare_next;
        end
    end

    // Output registers hold the head; entries leave in arrival order.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            out_valid_out <= 1'b0;
            out_data_out  <= '0;
            out_len_out   <= '0;
            out_cos_out   <= '0;
            out_vid_out   <= '0;
            out_queue_out <= '0;
        end else if (head_free) begin
            out_valid_out <= spare_valid_reg || accept;
            {out_data_out, out_len_out, out_cos_out, out_vid_out, out_queue_out} <= head;
        end
    end

    // Occupancy accounting: admitted bytes add, freed bytes subtract on the named queue.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < QN; i++) begin
                qocc_reg[i] <= '0;
            end
            total_reg <= '0;
        end else begin
            for (int i = 0; i < QN; i++) begin
                qocc_reg[i] <= qocc_reg[i]
                    + ((accept && qsel == 4'(i)) ? nlen : '0)
                    - ((free_valid_in && free_queue_in == 4'(i)) ? DEPTH_W'(free_len_in) : '0);
            end
            total_reg <= total_reg + (accept ? nlen : '0) - (free_valid_in ? DEPTH_W'(free_len_in) : '0);
        end
    end

    // Pseudo-random source and drop statistics.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lfsr_reg     <= 16'hACE1;
            drop_reg     <= 1'b0;
            drop_cnt_reg <= '0;
            acc_cnt_reg  <= '0;
        end else begin
            if (take) begin
                lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
            end
            drop_reg     <= take && drop_now;
            drop_cnt_reg <= drop_cnt_reg + 32'(take && drop_now);
            acc_cnt_reg  <= acc_cnt_reg + 32'(accept);
        end
    end
    assign drop_out = drop_reg;

    // Register decode.
    wire        wr_en    = avs_write_in && !avs_waitrequest_out;
    wire        rd_en    = avs_read_in && !avs_waitrequest_out;
    wire [2:0]  sub_idx  = avs_address_in[4:2];
    wire [3:0]  prof_idx = avs_address_in[5:2];
    wire        hit_thr  = (avs_address_in[7:5] == REG_COS_THR0[7:5]);
    wire        hit_pmap = (avs_address_in[7:5] == REG_COS_PROF0[7:5]);
    wire        hit_prof = (avs_address_in[7:6] == REG_PROF0[7:6]) && (32'(prof_idx) < PROFILES);
    wire [PCT_W-1:0] new_thr = avs_writedata_in[PCT_W-1:0];
    logic [PCT_W+3:0] thr_sum;
    always_comb begin
        thr_sum = '0;
        for (int i = 0; i < NUM_PRIO; i++) begin
            thr_sum = thr_sum + ((hit_thr && sub_idx == 3'(i)) ? (PCT_W+4)'(new_thr) : (PCT_W+4)'(cos_thr_reg[i]));
        end
    end
    // Thresholds reset to full scale each, so their sum starts above full scale; lowering
    // one is always let through, otherwise no threshold could ever be written.
    wire thr_ok  = (new_thr <= PCT_W'(PCT_FULL))
        && ((thr_sum <= (PCT_W+4)'(PCT_FULL)) || (new_thr <= cos_thr_reg[sub_idx]));
    wire [PROF_ID_W-1:0] wid = avs_writedata_in[PROF_ID_LSB +: PROF_ID_W];
    wire prof_ok = (wid <= PROF_ID_W'(PROFILE_ID_MAX))
        && (avs_writedata_in[PROF_MIN_LSB +: PCT_W] <= PCT_W'(PCT_FULL))
        && (avs_writedata_in[PROF_MAX_LSB +: PCT_W] <= PCT_W'(PCT_FULL))
        && (avs_writedata_in[PROF_PROB_LSB +: PCT_W] <= PCT_W'(PCT_FULL));
    wire mapped  = (avs_address_in <= REG_TOTAL_OCC) || hit_thr || hit_pmap || hit_prof;
    wire refuse  = (hit_thr && !thr_ok) || (hit_prof && !prof_ok) || !mapped;

    logic [31:0] rdata;
    always_comb begin
        rdata = RESP_ERR_VAL;
        if (hit_thr) rdata = 32'(cos_thr_reg[sub_idx]);
        else if (hit_pmap) rdata = 32'(cos_prof_reg[sub_idx]);
        else if (hit_prof) rdata = prof_reg[prof_idx];
        else case (avs_address_in)
            REG_CTRL:       rdata = ctrl_reg;
            REG_PORT_SIZE:  rdata = 32'(port_size_reg);
            REG_PORT_THR:   rdata = 32'(port_thr_reg);
            REG_DEFAULT_UP: rdata = 32'(default_up_reg);
            REG_STATUS:     rdata = {30'h0, cfg_err_reg, buf_full};
            REG_DROP_CNT:   rdata = drop_cnt_reg;
            REG_ACCEPT_CNT: rdata = acc_cnt_reg;
            REG_TOTAL_OCC:  rdata = 32'(total_reg);
            default:        rdata = RESP_ERR_VAL;
        endcase
    end

    // Bus slave: waitrequest stays high for the first cycle of each request, answer next cycle.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= '0;
            avs_response_out    <= RESP_OKAY;
        end else begin
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
            if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
                avs_readdata_out <= rdata;
                avs_response_out <= refuse ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    // Configuration writes; a refused threshold or profile write leaves state unchanged.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_reg       <= '0;
            port_size_reg  <= DEPTH_W'(PORT_SIZE_RST);
            port_thr_reg   <= DEPTH_W'(PORT_SIZE_RST);
            default_up_reg <= '0;
            cfg_err_reg    <= 1'b0;
            for (int i = 0; i < NUM_PRIO; i++) begin
                cos_thr_reg[i]  <= PCT_W'(PCT_FULL);
                cos_prof_reg[i] <= '0;
            end
            for (int i = 0; i < PROFILES; i++) begin
                prof_reg[i] <= {PROF_ID_W'(0), PCT_W'(0), 1'b0, PCT_W'(PCT_FULL), 1'b0, PCT_W'(PCT_FULL)};
            end
        end else if (wr_en && avs_byteenable_in == 4'hF) begin
            cfg_err_reg <= refuse;
            if (hit_thr && thr_ok) cos_thr_reg[sub_idx] <= new_thr;
            else if (hit_pmap) cos_prof_reg[sub_idx] <= avs_writedata_in[PROF_IDX_W-1:0];
            else if (hit_prof && prof_ok) prof_reg[prof_idx] <= avs_writedata_in;
            else case (avs_address_in)
                REG_CTRL:       ctrl_reg       <= avs_writedata_in;
                REG_PORT_SIZE:  port_size_reg  <= avs_writedata_in[DEPTH_W-1:0];
                REG_PORT_THR:   port_thr_reg   <= avs_writedata_in[DEPTH_W-1:0];
                REG_DEFAULT_UP: default_up_reg <= avs_writedata_in[2:0];
                default:        cfg_err_reg    <= refuse;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: dv/qcd_properties.sv
// Concurrent checks on the register bus and drop ports of the admission block.
`timescale 1ns/1ps
`default_nettype none
module qcd_properties
    import qcd_pkg::*;
#(
    parameter int PROFILES = NUM_PROFILES, // Profile slots.
    parameter int DW       = DATA_W        // Frame word width.
) (
    input wire logic              clk_in,              // Clock.
    input wire logic              rst_in,              // Synchronous reset.
    input wire logic [ADDR_W-1:0] avs_address_in,      // Register address.
    input wire logic              avs_read_in,         // Read request.
    input wire logic              avs_write_in,        // Write request.
    input wire logic [31:0]       avs_writedata_in,    // Write data.
    input wire logic              avs_waitrequest_out, // Stall.
    input wire logic [1:0]        avs_response_out,    // Response code.
    input wire logic              in_valid_in,         // Frame valid.
    input wire logic              in_ready_out,        // Frame ready.
    input wire logic              drop_out             // Drop pulse.
);
    // One clock domain, so clocking and reset masking are shared by every check.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Decodes of a taken request; the profile field check needs the whole id, not a truncated one.
    wire logic req_taken = (avs_read_in || avs_write_in) && avs_waitrequest_out;
    wire logic wr_taken  = avs_write_in && req_taken;
    wire logic hi_hole   = avs_address_in >= 8'hC0;
    wire logic thr_area  = avs_address_in >= REG_COS_THR0 && avs_address_in < REG_COS_PROF0;
    wire logic prof_area = avs_address_in >= REG_PROF0 && avs_address_in < 8'hC0;
    wire logic pct_big   = avs_writedata_in[6:0] > 7'h64;
    wire logic id_big    = avs_writedata_in[31:23] > 9'h180;

    a_wait_reset: assert property ($past(rst_in) |-> avs_waitrequest_out && !drop_out)
        else $error("stall or drop wrong right after reset");
    a_answer_next: assert property (req_taken |=> !avs_waitrequest_out)
        else $error("bus answer not one cycle after the request");
    a_answer_once: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("bus answer stood longer than one cycle");
    a_idle_stall: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer given without a request");
    a_hole_error: assert property (req_taken && hi_hole |=> avs_response_out == RESP_SLVERR)
        else $error("unmapped access not refused");
    a_pct_error: assert property (wr_taken && thr_area && pct_big |=> avs_response_out == RESP_SLVERR)
        else $error("threshold above full scale not refused");
    a_id_error: assert property (wr_taken && prof_area && id_big |=> avs_response_out == RESP_SLVERR)
        else $error("profile id above range not refused");
    a_drop_cause: assert property (drop_out |-> $past(in_valid_in && in_ready_out))
        else $error("drop pulse without an accepted frame");

    cover property (drop_out);
    cover property (req_taken && hi_hole);
    cover property (in_valid_in && in_ready_out ##1 !drop_out);
endmodule
bind queue_congestion_drop qcd_properties #(.PROFILES(PROFILES), .DW(DW)) chk (
    .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_waitrequest_out(avs_waitrequest_out),
    .avs_response_out(avs_response_out), .in_valid_in(in_valid_in), .in_ready_out(in_ready_out),
    .drop_out(drop_out));
`default_nettype wire

// File: dv/qcd_writer_model.sv
// Queue writer model that takes admitted frames with stalls and frees them afterwards.
`timescale 1ns/1ps
`default_nettype none
module qcd_writer_model (
    input  wire logic        clk_in,         // Clock.
    input  wire logic        rst_in,         // Synchronous reset.
    input  wire logic        out_valid_in,   // Admitted frame valid.
    input  wire logic [3:0]  out_queue_in,   // Queue of the frame.
    input  wire logic [15:0] out_len_in,     // Frame length.
    input  wire logic        hold_in,        // Keep taken frames queued.
    output logic             out_ready_out,  // Writer takes the frame.
    output logic             free_valid_out, // Frame left the buffer.
    output logic [3:0]       free_queue_out, // Queue it left.
    output logic [15:0]      free_len_out    // Its length.
);
    logic [1:0] stall_reg;
    // Stall one cycle in four so that a slow writer is seen at the admission side.
    assign out_ready_out = stall_reg != 2'h3;
    // Every frame taken is freed one cycle later unless hold is high; then it stays queued.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stall_reg      <= 2'h0;
            free_valid_out <= 1'b0;
        end else begin
            stall_reg      <= stall_reg + 2'h1;
            free_valid_out <= out_valid_in && out_ready_out && !hold_in;
        end
        free_queue_out <= out_queue_in;
        free_len_out   <= out_len_in;
    end
endmodule
`default_nettype wire

// File: dv/queue_congestion_drop_tb.sv
// Self-checking bench for queue admission, tail drop and random early discard.
`timescale 1ns/1ps
`default_nettype none
module queue_congestion_drop_tb;
    import qcd_pkg::*;
    logic              clk_in, rst_in, avs_read, avs_write, in_valid, in_mcast, drop_seen, hold;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0]       avs_writedata, rd;
    logic [3:0]        avs_byteenable;
    logic [15:0]       in_len;
    logic [2:0]        in_cos;
    logic [1:0]        rsp;
    wire logic [31:0]  avs_readdata;
    wire logic [1:0]   avs_response;
    wire logic         avs_waitrequest, in_ready, out_valid, out_ready, drop, free_valid;
    wire logic [3:0]   out_queue, free_queue;
    wire logic [15:0]  out_len, free_len;
    wire logic [2:0]   out_cos;
    wire logic [11:0]  out_vid;
    wire logic [63:0]  out_data;
    int                error_cnt, checked;

    queue_congestion_drop uut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address),
        .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_byteenable_in(avs_byteenable), .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest),
        .avs_response_out(avs_response), .in_valid_in(in_valid), .in_ready_out(in_ready),
        .in_data_in(64'h0123_4567_89AB_CDEF), .in_len_in(in_len), .in_cos_in(in_cos), .in_vid_in(12'h005),
        .in_mcast_in(in_mcast), .out_valid_out(out_valid), .out_ready_in(out_ready), .out_data_out(out_data),
        .out_len_out(out_len), .out_cos_out(out_cos), .out_vid_out(out_vid), .out_queue_out(out_queue),
        .free_valid_in(free_valid), .free_queue_in(free_queue), .free_len_in(free_len), .drop_out(drop));
    qcd_writer_model writer (.clk_in(clk_in), .rst_in(rst_in), .out_valid_in(out_valid), .out_queue_in(out_queue),
        .out_len_in(out_len), .out_ready_out(out_ready), .free_valid_out(free_valid), .free_queue_out(free_queue),
        .free_len_out(free_len), .hold_in(hold));

    // Free-running 25 MHz clock.
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic do_reset;
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
    endtask
    // The request holds until waitrequest is sampled low; data and response are taken at that edge.
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= d;
        avs_byteenable <= 4'hF;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        rd = avs_readdata;
        rsp = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 100) error_cnt++;
    endtask
    // Offers one frame, then checks the drop pulse in the cycle after the frame was taken.
    task automatic frame(input logic [15:0] len, input logic [2:0] cos, input logic mc, input logic exp_drop);
        int n;
        n = 0;
        @(posedge clk_in);
        in_valid <= 1'b1;
        in_len   <= len;
        in_cos   <= cos;
        in_mcast <= mc;
        do begin
            @(posedge clk_in);
            n++;
        end while (in_ready !== 1'b1 && n < 100);
        if (n >= 100) error_cnt++;
        in_valid <= 1'b0;
        @(posedge clk_in);
        drop_seen = drop;
        chk({31'h0, drop_seen}, {31'h0, exp_drop});
    endtask
    function automatic logic [31:0] prof(input logic [8:0] id, input logic [6:0] mn, mx, pb);
        return {id, pb, 1'b0, mx, 1'b0, mn};
    endfunction

    // Main sequence: register checks, tail drop, then discard profiles after a second reset.
    initial begin
        error_cnt = 0;
        checked = 0;
        rst_in = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        in_valid = 1'b0;
        in_len = 16'h0;
        in_cos = 3'h0;
        in_mcast = 1'b0;
        hold = 1'b0;
        do_reset;
        bus(1'b0, REG_PORT_SIZE, 32'h0);
        chk(rd, PORT_SIZE_RST);
        for (int i = 0; i < NUM_PRIO; i++) begin
            bus(1'b0, REG_COS_THR0 + ADDR_W'(i * 4), 32'h0);
            chk(rd, 32'h0000_0064);
        end
        bus(1'b0, 8'hFC, 32'h0);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        bus(1'b1, REG_COS_THR0, 32'h0000_0065);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd & 32'h2, 32'h2);
        bus(1'b1, REG_COS_THR0 + 8'h0C, 32'h0000_0032);
        chk({30'h0, rsp}, {30'h0, RESP_OKAY});
        bus(1'b1, REG_COS_THR0 + 8'h0C, 32'h0000_0040);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        bus(1'b0, REG_COS_THR0 + 8'h0C, 32'h0);
        chk(rd, 32'h0000_0032);
        bus(1'b1, REG_PROF0, prof(9'h181, 7'h00, 7'h0A, 7'h00));
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        bus(1'b1, REG_PROF0, prof(9'h180, 7'h00, 7'h0A, 7'h00));
        chk({30'h0, rsp}, {30'h0, RESP_OKAY});
        bus(1'b0, REG_PROF0, 32'h0);
        chk(rd, prof(9'h180, 7'h00, 7'h0A, 7'h00));
        bus(1'b1, REG_COS_THR0 + 8'h14, 32'h0);
        bus(1'b1, REG_CTRL, 32'h0ABC_0006);
        frame(16'h0010, 3'h5, 1'b1, 1'b0);
        chk({29'h0, out_cos}, 32'h0);
        chk({20'h0, out_vid}, 32'h0000_0ABC);
        chk(out_data[31:0], 32'h89AB_CDEF);
        bus(1'b1, REG_CTRL, 32'h0000_0001);
        frame(16'h0010, 3'h5, 1'b1, 1'b1);
        frame(16'h0010, 3'h5, 1'b0, 1'b0);
        bus(1'b1, REG_PORT_SIZE, 32'h0000_0100);
        frame(16'h0101, 3'h0, 1'b0, 1'b1);
        frame(16'h0100, 3'h0, 1'b0, 1'b0);
        bus(1'b0, REG_ACCEPT_CNT, 32'h0);
        chk(rd, 32'h0000_0003);
        bus(1'b0, REG_DROP_CNT, 32'h0);
        chk(rd, 32'h0000_0002);
        bus(1'b0, REG_TOTAL_OCC, 32'h0);
        chk(rd, 32'h0);
        hold <= 1'b1;
        do_reset;
        bus(1'b1, REG_CTRL, 32'h0000_0009);
        bus(1'b1, REG_COS_PROF0, 32'h0);
        bus(1'b1, REG_PROF0, prof(9'h001, 7'h00, 7'h0A, 7'h00));
        frame(16'h2000, 3'h0, 1'b0, 1'b0);
        frame(16'h0100, 3'h0, 1'b0, 1'b1);
        bus(1'b1, REG_PROF0, prof(9'h001, 7'h00, 7'h32, 7'h64));
        frame(16'h0100, 3'h0, 1'b0, 1'b1);
        bus(1'b1, REG_PROF0, prof(9'h001, 7'h00, 7'h32, 7'h00));
        frame(16'h0100, 3'h0, 1'b0, 1'b0);
        bus(1'b0, REG_DROP_CNT, 32'h0);
        chk(rd, 32'h0000_0002);
        close_out;
    end

    // The tests need under two hundred cycles; a hang stops here and counts as a mismatch.
    initial begin
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        close_out;
    end
endmodule
`default_nettype wire
